/* File: logic/prt_rtc_timestamp.sv */
`default_nettype none
// Function
// - Nanoseconds count is 32 bits and returns to zero after one second.
// - 48-bit seconds advance on nanosecond rollover, wrapping only at full.
// - Increment unit is one 2^20th of a nanosecond.
// - A 20-bit fraction extends nanoseconds as one accumulator.
// - Increment is 26 bits: top 6 to ns, low 20 to fraction.
// - Every clock, accumulator becomes its value plus current increment.
// - Accumulator starts at zero after reset, then advances smoothly.
// - Largest step per cycle is 64 ns, enough for 40 ns periods.
// - Synchronised nanoseconds is controlled count plus offset, every clock.
// - Seconds advance on synchronised rollover, plus a seconds offset.
// - An 8 kHz tick derives from synchronised nanoseconds.
// - A PTP Ethertype frame, sent or received, gets a timestamp if it starts while its stamp writer is not busy.
// - Timestamps sample the controlled count, never the synchronised one.
// - Timestamps go into the packet buffer beside their frame.
// - Everything runs on the single reference clock.
// - Transmit stamp taken at start, written to bytes FC-FF after end.
// - A second 32-bit nanosecond output counts to all ones before wrapping.
module prt_rtc_timestamp
  import prt_pkg::*;
(
  input  wire logic                 mclk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic [INC_W-1:0]     inc_i,
  input  wire logic [NS_W-1:0]      off_ns_i,
  input  wire logic [SEC_W-1:0]     off_sec_i,
  input  wire logic                 off_load_i,
  input  wire logic                 tx_start_i,
  input  wire logic                 tx_end_i,
  input  wire logic                 tx_ptp_i,
  input  wire logic [TX_SECT_W-1:0] tx_sect_i,
  input  wire logic                 rx_start_i,
  input  wire logic                 rx_end_i,
  input  wire logic                 rx_ptp_i,
  input  wire logic [RX_SECT_W-1:0] rx_sect_i,
  output logic [NS_W-1:0]           rtc_ns_o,
  output logic [SEC_W-1:0]          rtc_sec_o,
  output logic [NS_W-1:0]           rtc_ns_1722_o,
  output logic [NS_W-1:0]           cf_ns_o,
  output logic                      tick_8khz_o,
  output prt_buf_wr_t               tx_buf_wr_o,
  output prt_buf_wr_t               rx_buf_wr_o,
  output logic                      tx_stamp_busy_o,
  output logic                      rx_stamp_busy_o
);
  logic [NS_W-1:0]   cf_ns_ff;
  logic [FRAC_W-1:0] cf_frac_ff;
  logic [SEC_W-1:0]  cf_sec_ff;
  logic [NS_W-1:0]   off_ns_ff;
  logic [SEC_W-1:0]  off_sec_ff;
  logic [NS_W-1:0]   sync_ns_ff;
  logic [SEC_W-1:0]  sync_sec_ff;
  logic [NS_W-1:0]   ns_1722_ff;
  logic              tick_ff;

  logic [FRAC_W:0]   frac_sum;
  logic [NS_W:0]     ns_raw;
  logic [NS_W:0]     ns_wrapped;
  logic [NS_W:0]     sync_wrapped;
  logic [SEC_W-1:0]  nxt_sync_sec;
  logic [NS_W-1:0]   nxt_1722;
  logic              nxt_tick;

  // Fraction and nanoseconds added as one wide accumulator
  always_comb begin
    frac_sum   = {1'b0, cf_frac_ff} + {1'b0, inc_i[FRAC_W-1:0]};
    ns_raw     = {1'b0, cf_ns_ff}
               + (NS_W+1)'(inc_i[INC_W-1:FRAC_W])
               + (NS_W+1)'(frac_sum[FRAC_W]);
    ns_wrapped = prt_ns_mod(ns_raw);
  end

  // Controlled-frequency count, stepped every reference clock
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cf_frac_ff <= 20'h00000;
      cf_ns_ff   <= 32'h00000000;
      cf_sec_ff  <= 48'h000000000000;
    end else begin
      cf_frac_ff <= frac_sum[FRAC_W-1:0];
      cf_ns_ff   <= ns_wrapped[NS_W-1:0];
      cf_sec_ff  <= cf_sec_ff + SEC_W'(ns_wrapped[NS_W]);
    end
  end

  // Both offsets latched on one strobe so no half correction shows
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      off_ns_ff  <= 32'h00000000;
      off_sec_ff <= 48'h000000000000;
    end else if (off_load_i) begin
      off_ns_ff  <= off_ns_i;
      off_sec_ff <= off_sec_i;
    end
  end

  always_comb begin
    sync_wrapped = prt_ns_mod({1'b0, cf_ns_ff} + {1'b0, off_ns_ff});
    nxt_sync_sec = cf_sec_ff + off_sec_ff
                 + SEC_W'(sync_wrapped[NS_W]);
    nxt_1722     = 32'(sync_sec_ff[31:0] * NS_PER_SEC) + sync_ns_ff;
    nxt_tick     = (sync_ns_ff % TICK_PERIOD_NS) < TICK_HALF_NS;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sync_ns_ff  <= 32'h00000000;
      sync_sec_ff <= 48'h000000000000;
    end else begin
      sync_ns_ff  <= sync_wrapped[NS_W-1:0];
      sync_sec_ff <= nxt_sync_sec;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ns_1722_ff <= 32'h00000000;
      tick_ff    <= 1'b0;
    end else begin
      ns_1722_ff <= nxt_1722;
      tick_ff    <= nxt_tick;
    end
  end

  assign rtc_ns_o      = sync_ns_ff;
  assign rtc_sec_o     = sync_sec_ff;
  assign rtc_ns_1722_o = ns_1722_ff;
  assign cf_ns_o       = cf_ns_ff;
  assign tick_8khz_o   = tick_ff;

  // Offset is left to software when reading stamps
  prt_stamp_writer #(
    .SECT_W (TX_SECT_W)
  ) u_tx_stamp (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (tx_start_i),
    .end_i     (tx_end_i),
    .ptp_i     (tx_ptp_i),
    .sect_i    (tx_sect_i),
    .cf_ns_i   (cf_ns_ff),
    .wr_o      (tx_buf_wr_o),
    .busy_o    (tx_stamp_busy_o)
  );

  prt_stamp_writer #(
    .SECT_W (RX_SECT_W)
  ) u_rx_stamp (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (rx_start_i),
    .end_i     (rx_end_i),
    .ptp_i     (rx_ptp_i),
    .sect_i    (rx_sect_i),
    .cf_ns_i   (cf_ns_ff),
    .wr_o      (rx_buf_wr_o),
    .busy_o    (rx_stamp_busy_o)
  );

  sequence s_after_run;
    !$past(sys_rst_i);
  endsequence

  a_cf_ns_range: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    cf_ns_ff < NS_PER_SEC)
    else $error("controlled nanoseconds reached one second");

  a_sec_advance: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_after_run ##0 (cf_ns_ff < $past(cf_ns_ff))
      |-> cf_sec_ff == $past(cf_sec_ff) + 48'h000000000001)
    else $error("seconds did not advance on rollover");

  a_frac_step: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_after_run |-> cf_frac_ff ==
      20'($past(cf_frac_ff) + $past(inc_i[FRAC_W-1:0])))
    else $error("fraction did not add the increment");

  a_ns_step_max: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_after_run ##0 (cf_ns_ff >= $past(cf_ns_ff))
      |-> cf_ns_ff - $past(cf_ns_ff) <= MAX_STEP_NS)
    else $error("nanosecond step above 64 ns");

  a_reset_zero: assert property (
    @(posedge mclk_i)
    sys_rst_i |=> cf_ns_ff == 32'h00000000 && cf_frac_ff == 20'h00000
      && cf_sec_ff == 48'h000000000000)
    else $error("controlled count not zero after reset");

  a_sync_sum: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_after_run ##0 ($past(off_ns_ff) < NS_PER_SEC) |-> rtc_ns_o < NS_PER_SEC
      && (rtc_ns_o == $past(cf_ns_ff) + $past(off_ns_ff)
      || rtc_ns_o == $past(cf_ns_ff) + $past(off_ns_ff) - NS_PER_SEC))
    else $error("synchronised nanoseconds wrong");

  a_offset_pair: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    off_load_i |=> off_ns_ff == $past(off_ns_i)
      && off_sec_ff == $past(off_sec_i))
    else $error("offsets not applied together");

  a_tick_level: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_after_run |-> tick_8khz_o ==
      (($past(sync_ns_ff) % TICK_PERIOD_NS) < TICK_HALF_NS))
    else $error("8 kHz tick level wrong");

  a_1722_track: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    !$past(sys_rst_i) && !$past(sys_rst_i, 2) && !$past(sys_rst_i, 3)
      && $past(rtc_sec_o) == $past(rtc_sec_o, 2)
      |-> rtc_ns_1722_o - $past(rtc_ns_1722_o)
        == $past(rtc_ns_o) - $past(rtc_ns_o, 2))
    else $error("1722 count does not follow nanoseconds");
endmodule : prt_rtc_timestamp
`default_nettype wire

/* File: pkg/prt_pkg.sv */
`default_nettype none
package prt_pkg;
  localparam int          NS_W        = 32;
  localparam int          FRAC_W      = 20;
  localparam int          INC_W       = 26;
  localparam int          SEC_W       = 48;
  localparam int          SECT_ADDR_W = 8;
  localparam int          TX_SECT_W   = 3;
  localparam int          RX_SECT_W   = 4;
  localparam int          BUF_ADDR_W  = 12;
  localparam int          TS_BYTES    = 4;
  localparam logic [31:0] NS_PER_SEC  = 32'h3B9ACA00;
  localparam logic [31:0] MAX_STEP_NS = 32'h00000040;
  // 8 kHz: 125000 ns period, high for the first half
  localparam logic [31:0] TICK_PERIOD_NS = 32'h0001E848;
  localparam logic [31:0] TICK_HALF_NS   = 32'h0000F424;
  localparam logic [7:0]  TS_OFFSET      = 8'hFC;

  typedef struct packed {
    logic                  we;
    logic [BUF_ADDR_W-1:0] addr;
    logic [7:0]            data;
  } prt_buf_wr_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_WRITE = 2'b10
  } prt_stamp_st_t;

  // Reduce a sum below one second; msb returns the seconds carry
  function automatic logic [NS_W:0] prt_ns_mod(input logic [NS_W:0] sum);
    logic [NS_W:0] res;
    res = sum;
    if (sum >= {1'b0, NS_PER_SEC}) begin
      res = {1'b1, sum[NS_W-1:0] - NS_PER_SEC};
    end
    return res;
  endfunction : prt_ns_mod
endpackage : prt_pkg
`default_nettype wire

/* File: logic/prt_stamp_writer.sv */
`default_nettype none
module prt_stamp_writer
  import prt_pkg::*;
#(
  parameter int SECT_W = 3
) (
  input  wire logic              mclk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              start_i,
  input  wire logic              end_i,
  input  wire logic              ptp_i,
  input  wire logic [SECT_W-1:0] sect_i,
  input  wire logic [NS_W-1:0]   cf_ns_i,
  output prt_buf_wr_t            wr_o,
  output logic                   busy_o
);
  prt_stamp_st_t     st_ff;
  logic              armed_ff;
  logic [NS_W-1:0]   stamp_ff;
  logic [SECT_W-1:0] sect_ff;
  logic [1:0]        idx_ff;
  prt_buf_wr_t       wr_ff;
  logic              launch;

  assign launch = end_i && armed_ff && (st_ff == ST_IDLE);

  // Sample the smooth count at frame start, PTP frames only
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      armed_ff <= 1'b0;
      stamp_ff <= 32'h00000000;
    end else if (start_i && ptp_i && !busy_o) begin
      // A start while a stamp is held or written is ignored
      armed_ff <= 1'b1;
      stamp_ff <= cf_ns_i;
    end else if (launch) begin
      armed_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_ff   <= ST_IDLE;
      sect_ff <= '0;
      idx_ff  <= 2'h0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          if (launch) begin
            st_ff   <= ST_WRITE;
            sect_ff <= sect_i;
            idx_ff  <= 2'h0;
          end
        end
        ST_WRITE: begin
          idx_ff <= idx_ff + 2'h1;
          if (idx_ff == 2'(TS_BYTES - 1)) begin
            st_ff <= ST_IDLE;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // One byte per cycle into the top four bytes, low byte first
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wr_ff <= '0;
    end else begin
      wr_ff.we   <= (st_ff == ST_WRITE);
      wr_ff.addr <= BUF_ADDR_W'({sect_ff, TS_OFFSET | 8'(idx_ff)});
      wr_ff.data <= stamp_ff[8*idx_ff +: 8];
    end
  end

  assign wr_o   = wr_ff;
  assign busy_o = armed_ff || (st_ff != ST_IDLE);

  sequence s_stamp_bytes;
    wr_o.addr[7:0] == 8'hFC && wr_o.we ##1
    wr_o.addr[7:0] == 8'hFD && wr_o.we ##1
    wr_o.addr[7:0] == 8'hFE && wr_o.we ##1
    wr_o.addr[7:0] == 8'hFF && wr_o.we;
  endsequence

  a_stamp_write: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    launch |=> ##1 s_stamp_bytes ##1 !wr_o.we)
    else $error("stamp not written to top four bytes");

  a_stamp_sample: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    start_i && ptp_i && !busy_o |=> stamp_ff == $past(cf_ns_i))
    else $error("stamp is not the controlled count");

  a_stamp_ptp_only: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    !armed_ff && !(start_i && ptp_i) |=> !armed_ff)
    else $error("capture armed without a PTP frame");

  a_stamp_hold: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    armed_ff |=> stamp_ff == $past(stamp_ff))
    else $error("held stamp changed before it was written");
endmodule : prt_stamp_writer
`default_nettype wire

/* File: dv/tb.sv */
`default_nettype none
module tb
  import prt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              mclk_i, sys_rst_i, off_load_i, run;
  logic              tx_start_i, tx_end_i, tx_ptp_i;
  logic              rx_start_i, rx_end_i, rx_ptp_i;
  logic [2:0]        tx_sect_i;
  logic [3:0]        rx_sect_i;
  logic [INC_W-1:0]  inc_i;
  logic [31:0]       off_ns_i, rtc_ns_o, rtc_ns_1722_o, cf_ns_o;
  logic [SEC_W-1:0]  off_sec_i, rtc_sec_o;
  logic              tick_8khz_o, tx_stamp_busy_o, rx_stamp_busy_o;
  prt_buf_wr_t       tx_buf_wr_o, rx_buf_wr_o;
  logic [51:0]       m_acc, sm;
  logic [47:0]       m_cs, m_os, e_sec;
  logic [31:0]       m_on, e_ns, e_1722;
  logic [32:0]       sy;
  logic              c, s1, e_tick;
  logic [19:0]       q_tx[$], q_rx[$];
  int                n_mismatch, total_checks;

  prt_rtc_timestamp DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .inc_i(inc_i), .off_ns_i(off_ns_i), .off_sec_i(off_sec_i),
    .off_load_i(off_load_i), .tx_start_i(tx_start_i), .tx_end_i(tx_end_i),
    .tx_ptp_i(tx_ptp_i), .tx_sect_i(tx_sect_i), .rx_start_i(rx_start_i),
    .rx_end_i(rx_end_i), .rx_ptp_i(rx_ptp_i), .rx_sect_i(rx_sect_i),
    .rtc_ns_o(rtc_ns_o), .rtc_sec_o(rtc_sec_o),
    .rtc_ns_1722_o(rtc_ns_1722_o), .cf_ns_o(cf_ns_o),
    .tick_8khz_o(tick_8khz_o), .tx_buf_wr_o(tx_buf_wr_o),
    .rx_buf_wr_o(rx_buf_wr_o), .tx_stamp_busy_o(tx_stamp_busy_o),
    .rx_stamp_busy_o(rx_stamp_busy_o));

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic results;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  task automatic check(input string nm, input logic [63:0] s,
                       input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", nm, e, s);
    end
  endtask : check

  // Reference counter, offsets and outputs
  always @(posedge mclk_i) begin
    sm = m_acc + 52'(inc_i);
    c = sm[51:20] >= NS_PER_SEC;
    if (c) sm[51:20] = sm[51:20] - NS_PER_SEC;
    sy = {1'b0, m_acc[51:20]} + {1'b0, m_on};
    s1 = sy >= {1'b0, NS_PER_SEC};
    if (s1) sy = sy - {1'b0, NS_PER_SEC};
    if (sys_rst_i) begin
      {m_acc, m_cs, m_on, m_os, e_ns, e_sec, e_1722, e_tick} <= '0;
    end else begin
      m_acc <= sm;
      m_cs <= m_cs + 48'(c);
      if (off_load_i) begin
        m_on <= off_ns_i;
        m_os <= off_sec_i;
      end
      e_ns <= sy[31:0];
      e_sec <= m_cs + m_os + 48'(s1);
      e_1722 <= e_sec[31:0] * NS_PER_SEC + e_ns;
      e_tick <= (e_ns % TICK_PERIOD_NS) < TICK_HALF_NS;
    end
  end

  task automatic wr_chk(input bit rx, input prt_buf_wr_t w);
    logic [19:0] e;
    if ((rx ? q_rx.size() : q_tx.size()) == 0) begin
      check("unexpected write", 64'h1, 64'h0);
    end else begin
      e = rx ? q_rx.pop_front() : q_tx.pop_front();
      check("buf_wr", 64'({w.addr, w.data}), 64'(e));
    end
  endtask : wr_chk

  always @(negedge mclk_i) begin
    if (run) begin
      check("cf_ns", 64'(cf_ns_o), 64'(m_acc[51:20]));
      check("rtc_ns", 64'(rtc_ns_o), 64'(e_ns));
      check("rtc_sec", 64'(rtc_sec_o), 64'(e_sec));
      check("ns_1722", 64'(rtc_ns_1722_o), 64'(e_1722));
      check("tick", 64'(tick_8khz_o), 64'(e_tick));
      if (tx_buf_wr_o.we !== 1'b0) wr_chk(1'b0, tx_buf_wr_o);
      if (rx_buf_wr_o.we !== 1'b0) wr_chk(1'b1, rx_buf_wr_o);
    end
  end

  // Offsets change level after the load pulse to prove sampling
  task automatic load(input logic [31:0] n, input logic [47:0] s);
    @(posedge mclk_i);
    #2;
    {off_ns_i, off_sec_i, off_load_i} = {n, s, 1'b1};
    @(posedge mclk_i);
    #2;
    {off_ns_i, off_sec_i, off_load_i} = {~n, ~s, 1'b0};
    repeat (20) @(posedge mclk_i);
  endtask : load

  task automatic frame(input bit rx, input bit ptp, input bit dbl,
                       input logic [3:0] sect);
    logic [31:0] st;
    int k;
    @(posedge mclk_i);
    #2;
    st = m_acc[51:20];
    {rx_start_i, tx_start_i, rx_ptp_i, tx_ptp_i} =
      {rx, !rx, rx & ptp, !rx & ptp};
    @(posedge mclk_i);
    #2;
    {rx_start_i, tx_start_i} = {dbl & rx, dbl & !rx};
    {rx_ptp_i, tx_ptp_i} = {rx, !rx};
    check("busy", 64'(rx ? rx_stamp_busy_o : tx_stamp_busy_o),
          64'(ptp));
    check("stamp_sync", 64'(rtc_ns_o),
          64'(({1'b0, st} + {1'b0, m_on}) % {1'b0, NS_PER_SEC}));
    @(posedge mclk_i);
    #2;
    {rx_start_i, tx_start_i, rx_ptp_i, tx_ptp_i} = '0;
    repeat (3) @(posedge mclk_i);
    #2;
    {rx_end_i, tx_end_i, rx_sect_i, tx_sect_i} = {rx, !rx, sect, sect[2:0]};
    for (k = 0; k < TS_BYTES && ptp; k++) begin
      if (rx) q_rx.push_back({sect, TS_OFFSET + 8'(k), st[8*k +: 8]});
      else q_tx.push_back({1'b0, sect[2:0], TS_OFFSET + 8'(k), st[8*k +: 8]});
    end
    @(posedge mclk_i);
    #2;
    {rx_end_i, tx_end_i} = 2'b00;
    k = 0;
    while ((rx ? rx_stamp_busy_o : tx_stamp_busy_o) !== 1'b0) begin
      if (k++ == 30) begin
        n_mismatch++;
        results();
      end
      @(posedge mclk_i);
      #2;
    end
    repeat (2) @(posedge mclk_i);
    check("writes left", 64'(q_rx.size() + q_tx.size()), 64'h0);
  endtask : frame

  initial begin
    void'($urandom(32'h5724));
    {run, off_load_i, inc_i, off_ns_i, off_sec_i} = '0;
    sys_rst_i = 1'b1;
    {tx_start_i, tx_end_i, tx_ptp_i, tx_sect_i} = '0;
    {rx_start_i, rx_end_i, rx_ptp_i, rx_sect_i} = '0;
    repeat (8) @(posedge mclk_i);
    #2;
    sys_rst_i = 1'b0;
    run = 1'b1;
    inc_i = 26'h1900000;
    load(NS_PER_SEC - 32'h12C, '1);
    load(TICK_HALF_NS - 32'hC8, 48'h5);
    load(TICK_PERIOD_NS - 32'hC8, 48'h0);
    #2;
    inc_i = 26'h3FFFFFF;
    repeat (40) @(posedge mclk_i);
    repeat (400) begin
      @(posedge mclk_i);
      #2;
      inc_i = 26'($urandom);
      off_load_i = ($urandom % 8) == 0;
      off_ns_i = $urandom % NS_PER_SEC;
      off_sec_i = {16'($urandom), 32'($urandom)};
    end
    @(posedge mclk_i);
    #2;
    off_load_i = 1'b0;
    frame(1'b0, 1'b1, 1'b0, 4'($urandom));
    frame(1'b0, 1'b0, 1'b0, 4'h3);
    frame(1'b1, 1'b1, 1'b1, 4'hF);
    frame(1'b1, 1'b0, 1'b0, 4'h1);
    frame(1'b0, 1'b1, 1'b1, 4'h7);
    frame(1'b1, 1'b1, 1'b0, 4'($urandom));
    results();
  end
endmodule : tb
`default_nettype wire
